// ==== src/pulse_shaper_pkg.sv ====
// Constants shared by the output pulse-width and coarse phase shaper.
//
// Operation
// R1: Zero high count gives equal duty cycle
// R2: Nonzero count sets exact high cycles
// R3: Software keeps high count below divider
// R4: Pulses always high-going; invert complementary pad
// R5: Shaping and adjust work in every mode
// R6: Adjust edges in whole divider clock periods
// R7: Adjusted phases never below two cycles
// R8: One adjust spans up to 2^32 per phase
// R9: Positive lengthens, negative shortens, one period
// R10: Equal duty splits adjust across both phases
// R11: Pulse mode adjusts the low phase only
// R12: Any number of successive adjust requests
// R13: Software spreads large shifts over time
// R14: Single-ended copies match, optional complement invert
// R15: Swing code 00..11 is 410/600/750/900 mV
// R16: Single stage one buffer, dual two
// R17: 32-bit integer divider forms output clock
// R18: New settings apply at next period start

package pulse_shaper_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int DIV_W  = 32;                  // Divider and high count
    localparam int LEN_W  = 35;                  // Phase length arithmetic
    localparam int SWG_W  = 2;                   // Swing select code
    localparam int MV_W   = 10;                  // Nominal swing in mV
    localparam int NUM_BUF_DUAL = 2;             // Buffers in a dual stage

    ////////////////////////////////////////////////////////////////////////
    // Divider and adjust limits
    localparam logic [DIV_W-1:0] MIN_DIV        = 32'h0000_0002;
    localparam logic [DIV_W-1:0] COARSE_MAX_BAD = 32'h0000_0004;
    localparam logic [LEN_W-1:0] MIN_ADJ_PHASE  = 35'h0_0000_0002;
    localparam logic [LEN_W-1:0] MIN_PHASE      = 35'h0_0000_0001;
    localparam logic signed [LEN_W-1:0] PHASE_LIM = 35'sh1_0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // Nominal differential swing per code
    localparam logic [MV_W-1:0] SWING_MV_00 = 10'h19a;   // 410 mV
    localparam logic [MV_W-1:0] SWING_MV_01 = 10'h258;   // 600 mV
    localparam logic [MV_W-1:0] SWING_MV_10 = 10'h2ee;   // 750 mV
    localparam logic [MV_W-1:0] SWING_MV_11 = 10'h384;   // 900 mV

    // Output phase state
    typedef enum logic [0:0] {
        PH_HIGH = 1'b0,
        PH_LOW  = 1'b1
    } phase_t;

endpackage : pulse_shaper_pkg

// ==== src/output_pulse_width_and_phase_shaper.sv ====
// Output stage shaper: integer divide, pulse width, coarse phase, pads.
`timescale 1ns/1ns
`default_nettype none

module output_pulse_width_and_phase_shaper
    import pulse_shaper_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      reset,
    input  wire logic [DIV_W-1:0]          out_div,
    input  wire logic [DIV_W-1:0]          duty_high,
    input  wire logic signed [LEN_W-1:0]   coarse_phase_step,
    input  wire logic                      step_valid,
    input  wire logic                      dual_stage,
    input  wire logic [NUM_BUF_DUAL-1:0]   diff_mode,
    input  wire logic [NUM_BUF_DUAL-1:0]   comp_invert,
    input  wire logic [2*SWG_W-1:0]        swing_select,
    output logic [NUM_BUF_DUAL-1:0]        true_output_pad,
    output logic [NUM_BUF_DUAL-1:0]        complementary_output_pad,
    output logic [NUM_BUF_DUAL-1:0]        buffer_active,
    output logic [2*MV_W-1:0]              nominal_swing_mv,
    output logic                           period_start,
    output logic                           step_applied,
    output logic                           step_rejected,
    output logic                           step_pending
);

    ////////////////////////////////////////////////////////////////////////
    // State
    phase_t                    phase_q;        // Current output phase
    phase_t                    phase_d;
    logic [LEN_W-1:0]          cnt_q;          // Cycles left in this phase
    logic [LEN_W-1:0]          cnt_d;
    logic [LEN_W-1:0]          low_len_q;      // Low length of this period
    logic [LEN_W-1:0]          low_len_d;
    logic signed [LEN_W-1:0]   pend_q;         // Accumulated adjust
    logic signed [LEN_W-1:0]   pend_d;
    logic                      pend_vld_q;     // Adjust waiting for a period
    logic                      pend_vld_d;
    logic                      clk_out_q;      // Shaped clock before pads
    logic                      applied_q;
    logic                      rejected_q;
    logic                      start_q;

    ////////////////////////////////////////////////////////////////////////
    // Base period split, sampled only at period start
    logic [DIV_W-1:0]          eff_div;        // Divider floored at two
    logic                      equal_duty;     // High count of zero
    logic [LEN_W-1:0]          base_hi;
    logic signed [LEN_W-1:0]   base_lo_s;
    logic [LEN_W-1:0]          base_lo;
    logic                      adj_allowed;

    // Divider ratio below two cannot make a registered clock; floor it
    assign eff_div    = (out_div < MIN_DIV) ? MIN_DIV : out_div;     // see R17
    assign equal_duty = (duty_high == '0);                            // see R1

    // Equal duty: half (floor) high, rest low; else exact high count
    assign base_hi = equal_duty ? {3'h0, eff_div >> 1}                // see R1
                                : {3'h0, duty_high};                  // see R2
    assign base_lo_s = $signed({3'h0, eff_div}) - $signed(base_hi);
    // Guard against a high count at or above the divider ratio
    assign base_lo = (base_lo_s < $signed(MIN_PHASE)) ? MIN_PHASE
                                                      : base_lo_s;    // see R3

    // Coarse adjust is meaningless for divide ratios of four or less
    assign adj_allowed = (eff_div > COARSE_MAX_BAD);                  // see R7

    ////////////////////////////////////////////////////////////////////////
    // Split and clamp the pending adjust across the two phases
    logic signed [LEN_W-1:0]   adj_hi_raw;
    logic signed [LEN_W-1:0]   adj_lo_raw;
    logic signed [LEN_W-1:0]   adj_hi;
    logic signed [LEN_W-1:0]   adj_lo;
    logic signed [LEN_W-1:0]   new_hi_s;
    logic signed [LEN_W-1:0]   new_lo_s;
    logic [LEN_W-1:0]          next_hi;
    logic [LEN_W-1:0]          next_lo;
    logic                      use_adj;

    // Equal duty halves it, pulse mode keeps the high width fixed
    // Signed zero keeps the arithmetic shift signed inside the select
    assign adj_hi_raw = equal_duty ? (pend_q >>> 1)
                                   : $signed({LEN_W{1'b0}});   // see R10, R11
    assign adj_lo_raw = pend_q - adj_hi_raw;                    // see R10, R11

    // Each phase moves at most 2^32 cycles in one period
    assign adj_hi = (adj_hi_raw >  PHASE_LIM) ? PHASE_LIM :
                    (adj_hi_raw < -PHASE_LIM) ? -PHASE_LIM :
                    adj_hi_raw;                                       // see R8
    assign adj_lo = (adj_lo_raw >  PHASE_LIM) ? PHASE_LIM :
                    (adj_lo_raw < -PHASE_LIM) ? -PHASE_LIM :
                    adj_lo_raw;                                       // see R8

    // Positive adds cycles, negative removes them, in whole cycles
    assign new_hi_s = $signed(base_hi) + adj_hi;                  // see R6, R9
    assign new_lo_s = $signed(base_lo) + adj_lo;                  // see R6, R9

    assign use_adj = pend_vld_q && adj_allowed;

    // Adjusted phases stop at two cycles; pulse mode high is untouched
    assign next_hi = !use_adj || !equal_duty ? base_hi :
                     (new_hi_s < $signed(MIN_ADJ_PHASE)) ? MIN_ADJ_PHASE :
                     new_hi_s;                                        // see R7
    assign next_lo = !use_adj ? base_lo :
                     (new_lo_s < $signed(MIN_ADJ_PHASE)) ? MIN_ADJ_PHASE :
                     new_lo_s;                                        // see R7

    ////////////////////////////////////////////////////////////////////////
    // Phase sequencer
    logic phase_end;      // Last cycle of the current phase
    logic at_start;       // Next cycle begins a new output period

    assign phase_end = (cnt_q <= MIN_PHASE);
    assign at_start  = phase_end && (phase_q == PH_LOW);

    // New settings load only here, so a running period is never cut
    always_comb begin
        phase_d   = phase_q;
        cnt_d     = cnt_q - MIN_PHASE;
        low_len_d = low_len_q;
        if (phase_end) begin
            unique case (phase_q)
                PH_HIGH: begin
                    phase_d = PH_LOW;
                    cnt_d   = low_len_q;
                end
                PH_LOW: begin
                    phase_d   = PH_HIGH;                              // see R18
                    cnt_d     = next_hi;                              // see R18
                    low_len_d = next_lo;                              // see R18
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Adjust accumulator: further requests add up, none are lost
    logic consume;    // Pending adjust is taken at this period start

    assign consume = at_start && pend_vld_q;

    always_comb begin
        pend_d     = pend_q;
        pend_vld_d = pend_vld_q;
        if (consume) begin
            pend_d     = '0;
            pend_vld_d = 1'b0;
        end
        // A request in the consume cycle survives: set beats clear
        if (step_valid) begin
            pend_d     = (consume ? '0 : pend_q) + coarse_phase_step; // see R12
            pend_vld_d = 1'b1;                                        // see R12
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer and accumulator registers
    always_ff @(posedge clk) begin
        if (reset) begin
            phase_q    <= PH_LOW;
            cnt_q      <= MIN_PHASE;
            low_len_q  <= MIN_PHASE;
            pend_q     <= '0;
            pend_vld_q <= 1'b0;
        end else begin
            phase_q    <= phase_d;
            cnt_q      <= cnt_d;
            low_len_q  <= low_len_d;
            pend_q     <= pend_d;
            pend_vld_q <= pend_vld_d;
        end
    end

    // Shaped clock is high during the high phase only
    always_ff @(posedge clk) begin
        if (reset) begin
            clk_out_q  <= 1'b0;
            start_q    <= 1'b0;
            applied_q  <= 1'b0;
            rejected_q <= 1'b0;
        end else begin
            clk_out_q  <= (phase_d == PH_HIGH);                       // see R4
            start_q    <= at_start;
            applied_q  <= consume && adj_allowed;
            rejected_q <= consume && !adj_allowed;                    // see R7
        end
    end

    assign period_start  = start_q;
    assign step_applied  = applied_q;
    assign step_rejected = rejected_q;
    assign step_pending  = pend_vld_q;

    ////////////////////////////////////////////////////////////////////////
    // Output buffers, both fed from the one divider path
    for (genvar i = 0; i < NUM_BUF_DUAL; i++) begin : g_buf
        logic       en;          // Buffer present in this stage
        logic       comp_src;    // Complementary pad source
        logic       true_q;
        logic       comp_q;
        logic [MV_W-1:0] mv_q;
        logic [MV_W-1:0] mv_sel;

        // Second buffer exists only in a dual stage
        assign en = (i == 0) || dual_stage;                           // see R16

        // Differential always complements; single-ended copies or inverts
        assign comp_src = diff_mode[i] ? ~clk_out_q
                        : (comp_invert[i] ? ~clk_out_q : clk_out_q);  // see R14

        // Nominal swing decode of the two-bit select
        assign mv_sel = (swing_select[i*SWG_W +: SWG_W] == 2'h0) ? SWING_MV_00 :
                        (swing_select[i*SWG_W +: SWG_W] == 2'h1) ? SWING_MV_01 :
                        (swing_select[i*SWG_W +: SWG_W] == 2'h2) ? SWING_MV_10 :
                        SWING_MV_11;                                  // see R15

        // Absent buffer rests low on both pads
        always_ff @(posedge clk) begin
            if (reset) begin
                true_q <= 1'b0;
                comp_q <= 1'b0;
                mv_q   <= SWING_MV_00;
            end else begin
                true_q <= en && clk_out_q;                            // see R5
                comp_q <= en && comp_src;                             // see R4
                mv_q   <= mv_sel;
            end
        end

        assign true_output_pad[i]          = true_q;
        assign complementary_output_pad[i] = comp_q;
        assign buffer_active[i]            = en;
        assign nominal_swing_mv[i*MV_W +: MV_W] = mv_q;
    end

endmodule : output_pulse_width_and_phase_shaper

`default_nettype wire

// ==== test/shaper_checker.sv ====
// Port relation checker for the output shaper.
`timescale 1ns/1ns
`default_nettype none
module shaper_checker
    import pulse_shaper_pkg::*;
(
    input wire logic                    clk,
    input wire logic                    reset,
    input wire logic                    dual_stage,
    input wire logic [NUM_BUF_DUAL-1:0] diff_mode,
    input wire logic [NUM_BUF_DUAL-1:0] comp_invert,
    input wire logic [2*SWG_W-1:0]      swing_select,
    input wire logic                    step_valid,
    input wire logic [NUM_BUF_DUAL-1:0] true_output_pad,
    input wire logic [NUM_BUF_DUAL-1:0] complementary_output_pad,
    input wire logic [NUM_BUF_DUAL-1:0] buffer_active,
    input wire logic [2*MV_W-1:0]       nominal_swing_mv,
    input wire logic                    period_start,
    input wire logic                    step_applied,
    input wire logic                    step_rejected,
    input wire logic                    step_pending
);
    // One clock domain, so clocking and disable are shared
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////
    buf_count_a: assert property (buffer_active == {dual_stage, 1'b1})
        else $error("buffer count wrong");
    diff_pair_a: assert property (!$past(reset) && $past(diff_mode[0])
        |-> complementary_output_pad[0] == ~true_output_pad[0])
        else $error("differential pair not opposite");
    comp_inv_a: assert property (!$past(reset) && !$past(diff_mode[0])
        && $past(comp_invert[0]) |-> complementary_output_pad[0]
        == ~true_output_pad[0]) else $error("complement not inverted");
    rise_start_a: assert property ($past(period_start) == $rose(true_output_pad[0]))
        else $error("period start not with rise");
    apply_start_a: assert property (step_applied
        |-> period_start && !step_rejected) else $error("bad apply pulse");
    reject_start_a: assert property (step_rejected |-> period_start)
        else $error("reject pulse off period start");
    req_pending_a: assert property (step_valid |=> step_pending)
        else $error("request not pending");
    swing_code_a: assert property (!$past(reset)
        && $past(swing_select[1:0]) == 2'b11
        |-> nominal_swing_mv[MV_W-1:0] == SWING_MV_11)
        else $error("swing code 11 wrong");
endmodule : shaper_checker
bind output_pulse_width_and_phase_shaper shaper_checker i_shaper_checker (.*);
`default_nettype wire

// ==== test/clock_receiver_model.sv ====
// Downstream receiver that times the high and low phases of a pad.
`timescale 1ns/1ns
`default_nettype none
module clock_receiver_model (
    input  wire logic  clk,
    input  wire logic  pad,
    output logic [31:0] hi_len,
    output logic [31:0] lo_len
);
    logic        prev_q;  // Pad level at the previous edge
    logic [31:0] cnt_q;   // Cycles spent in the present phase
    // Latch a phase length when the level turns; restart the count
    always_ff @(posedge clk) begin
        prev_q <= pad;
        cnt_q  <= (pad != prev_q) ? 32'h1 : cnt_q + 32'h1;
        if (pad && !prev_q) lo_len <= cnt_q;
        if (!pad && prev_q) hi_len <= cnt_q;
    end
endmodule : clock_receiver_model
`default_nettype wire

// ==== test/output_pulse_width_and_phase_shaper_tb.sv ====
// Self-checking bench for the output shaper.
`timescale 1ns/1ns
`default_nettype none
module output_pulse_width_and_phase_shaper_tb;
    import pulse_shaper_pkg::*;
    logic                    clk, reset = 1'b1, step_valid = 1'b0;
    logic                    dual_stage = 1'b0;
    logic [DIV_W-1:0]        out_div = 32'h8, duty_high = 32'h0;
    logic signed [LEN_W-1:0] coarse_phase_step = '0;
    logic [NUM_BUF_DUAL-1:0] diff_mode = 2'h0, comp_invert = 2'h0;
    logic [NUM_BUF_DUAL-1:0] buffer_active, true_output_pad;
    logic [NUM_BUF_DUAL-1:0] complementary_output_pad;
    logic [2*SWG_W-1:0]      swing_select = 4'h0;
    logic [2*MV_W-1:0]       nominal_swing_mv;
    logic                    period_start, step_applied, step_rejected;
    logic                    step_pending, seen_app, seen_rej;
    logic [31:0]             hi_len, lo_len;
    int                      err_count = 0, total_checks = 0;
    output_pulse_width_and_phase_shaper i_output_pulse_width_and_phase_shaper (.*);
    clock_receiver_model i_clock_receiver_model (.clk(clk),
        .pad(true_output_pad[0]), .hi_len(hi_len), .lo_len(lo_len));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Compare one value, counting every comparison
    task automatic check(input string what, input logic [63:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done
    // Wait for a period start pulse; the watchdog bounds a missing one
    task automatic wait_ps;
        // Look just after each edge, once the registered pulse has settled
        do begin
            @(posedge clk);
            #1;
        end while (period_start !== 1'b1);
        seen_app |= step_applied;
        seen_rej |= step_rejected;
    endtask : wait_ps
    // Settle a setting, send one or two adjusts, judge the adjusted period
    task automatic do_step(input logic [31:0] div, duty,
        input logic signed [LEN_W-1:0] v1, v2,
        input logic [31:0] hi, lo, input logic rej);
        @(posedge clk);
        out_div   <= div;
        duty_high <= duty;
        wait_ps;
        wait_ps;
        seen_app = 1'b0;
        seen_rej = 1'b0;
        @(posedge clk);
        step_valid        <= 1'b1;
        coarse_phase_step <= v1;
        if (v2 != 0) begin
            @(posedge clk);
            coarse_phase_step <= v2;
        end
        @(posedge clk);
        step_valid <= 1'b0;
        wait_ps;
        wait_ps;
        // Pad rises one edge after the start pulse; receiver latches one later
        repeat (2) @(posedge clk);
        #1;
        check("applied", seen_app, !rej);
        check("rejected", seen_rej, rej);
        check("high len", hi_len, hi);
        check("low len", lo_len, lo);
    endtask : do_step
    // Pad pairing in differential, inverted and copied single-ended use
    task automatic t_pads(input logic dual, input logic [1:0] dm, ci);
        @(posedge clk);
        dual_stage  <= dual;
        diff_mode   <= dm;
        comp_invert <= ci;
        repeat (10) begin
            @(posedge clk);
            #1;
            check("buffers", buffer_active, {dual, 1'b1});
            check("copy", true_output_pad[1], dual & true_output_pad[0]);
            check("comp", complementary_output_pad[0],
                true_output_pad[0] ^ (dm[0] | ci[0]));
        end
    endtask : t_pads
    // Every swing code on both buffers
    task automatic t_swing;
        logic [MV_W-1:0] mv [4];
        mv = '{SWING_MV_00, SWING_MV_01, SWING_MV_10, SWING_MV_11};
        for (int c = 0; c < 4; c++) begin
            @(posedge clk);
            swing_select <= {2'(3 - c), 2'(c)};
            repeat (2) @(posedge clk);
            check("swing", nominal_swing_mv, {mv[3 - c], mv[c]});
        end
    endtask : t_swing
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk);
        check("reset pads", true_output_pad, 2'b00);
        reset <= 1'b0;
        do_step(8, 0, 0, 0, 4, 4, 0);
        do_step(9, 0, 0, 0, 4, 5, 0);
        do_step(10, 3, 0, 0, 3, 7, 0);
        do_step(8, 0, 4, 0, 6, 6, 0);
        do_step(12, 0, -4, 0, 4, 4, 0);
        do_step(10, 3, 5, 0, 3, 12, 0);
        do_step(8, 0, -10, 0, 2, 2, 0);
        do_step(8, 0, 2, 2, 6, 6, 0);
        do_step(4, 0, 2, 0, 2, 2, 1);
        t_pads(1'b1, 2'b01, 2'b10);
        t_pads(1'b0, 2'b00, 2'b00);
        t_pads(1'b1, 2'b00, 2'b11);
        t_swing;
        test_done;
    end
    // Hang guard, far beyond the few hundred cycles the run needs
    initial begin
        #400000;
        err_count++;
        test_done;
    end
endmodule : output_pulse_width_and_phase_shaper_tb
`default_nettype wire
